/* File: hdl/grw_actions.sv */
// gateway reset, flag clear and communication watchdog actions
// assumes actions and packet events arrive on this clock, one per cycle
`timescale 1ns/1ps
`include "grw_regs.svh"

module grw_actions
   import grw_pkg::*;
#(
   parameter int unsigned TICK_CYC = `GRW_TICK_CYC
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_act_valid,
   input wire logic [7:0] i_act_opcode,
   input wire logic [7:0] i_act_param,
   input wire logic i_pkt_valid,
   input wire logic [7:0] i_status_set,
   output logic o_cmd_enable,
   output logic o_reboot,
   output logic o_io_reset,
   output logic o_hw_kick,
   output logic o_hw_reset_req,
   output logic [7:0] o_status,
   output logic [7:0] o_interval
);

   function automatic logic is_op(input logic [7:0] op,
                                  input logic [7:0] code);
      is_op = (op == code);
   endfunction

   grw_state_t state_ff;
   grw_state_t nxt_state;
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic [7:0] interval_ff;
   logic [7:0] nxt_interval;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic cmd_enable_ff;
   logic reboot_ff;
   logic io_reset_ff;
   logic hw_kick_ff;
   logic hw_reset_req_ff;
   logic nxt_hw_reset_req;
   logic nxt_cmd_enable;
   logic nxt_reboot;
   logic nxt_io_reset;
   logic nxt_hw_kick;
   logic run;
   logic act;
   logic restart;
   logic expire;
   logic tick;

   assign run = (state_ff == GRW_ST_RUN);
   assign act = i_act_valid && run;
   assign restart = run && (i_pkt_valid ||
                    (act && is_op(i_act_opcode, `GRW_OP_TIMEOUT_PROG)));

   ////////////////////////////////////////////////////////////////////////
   // 100 ms tick, restarted with the watchdog count
   grw_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_clr(restart),
      .o_tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // communication watchdog
   assign expire = run && tick && !act && !i_pkt_valid &&
                   (|interval_ff) && (cnt_ff + 8'd1 >= interval_ff);

   always_comb
   begin
      nxt_interval = interval_ff;
      nxt_cnt = cnt_ff;
      if (act && is_op(i_act_opcode, `GRW_OP_TIMEOUT_PROG))
      begin
         nxt_interval = i_act_param;
      end
      if (restart)
      begin
         nxt_cnt = 8'h00;
      end
      else if (tick && cnt_ff != 8'hff)
      begin
         nxt_cnt = cnt_ff + 8'd1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         interval_ff <= `GRW_INTERVAL_RST;
         cnt_ff <= 8'h00;
      end
      else if (i_ce)
      begin
         interval_ff <= nxt_interval;
         cnt_ff <= nxt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // action sequencing
   always_comb
   begin
      nxt_state = state_ff;
      nxt_hw_reset_req = hw_reset_req_ff;
      case (state_ff)
         GRW_ST_RUN:
         begin
            if (act && is_op(i_act_opcode, `GRW_OP_REBOOT))
            begin
               nxt_state = GRW_ST_REBOOT;
            end
            else if (act && is_op(i_act_opcode, `GRW_OP_FORCED_RESET))
            begin
               nxt_state = GRW_ST_HALT;
               nxt_hw_reset_req = 1'b1;
            end
            else if (expire)
            begin
               nxt_state = GRW_ST_HALT;
               nxt_hw_reset_req = 1'b1;
            end
         end
         GRW_ST_REBOOT: nxt_state = GRW_ST_REBOOT;
         GRW_ST_HALT: nxt_state = GRW_ST_HALT;
         default: nxt_state = GRW_ST_RUN;
      endcase
      nxt_cmd_enable = (nxt_state == GRW_ST_RUN);
      nxt_reboot = (nxt_state == GRW_ST_REBOOT);
      nxt_io_reset = (nxt_state != GRW_ST_RUN);
      nxt_hw_kick = tick && (nxt_state == GRW_ST_RUN);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state_ff <= GRW_ST_RUN;
         hw_reset_req_ff <= 1'b0;
         cmd_enable_ff <= 1'b1;
         reboot_ff <= 1'b0;
         io_reset_ff <= 1'b0;
         hw_kick_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         state_ff <= nxt_state;
         hw_reset_req_ff <= nxt_hw_reset_req;
         cmd_enable_ff <= nxt_cmd_enable;
         reboot_ff <= nxt_reboot;
         io_reset_ff <= nxt_io_reset;
         hw_kick_ff <= nxt_hw_kick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status byte, set wins over clear
   always_comb
   begin
      nxt_status = status_ff;
      if (act && is_op(i_act_opcode, `GRW_OP_FLAG_CLEAR))
      begin
         nxt_status = status_ff & ~i_act_param;
      end
      nxt_status = nxt_status | i_status_set;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         status_ff <= `GRW_STATUS_RST;
      end
      else if (i_ce)
      begin
         status_ff <= nxt_status;
      end
   end

   assign o_cmd_enable = cmd_enable_ff;
   assign o_reboot = reboot_ff;
   assign o_io_reset = io_reset_ff;
   assign o_hw_kick = hw_kick_ff;
   assign o_hw_reset_req = hw_reset_req_ff;
   assign o_status = status_ff;
   assign o_interval = interval_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_reboot_req;
      i_ce && act && is_op(i_act_opcode, `GRW_OP_REBOOT);
   endsequence

   sequence s_forced_req;
      i_ce && act && is_op(i_act_opcode, `GRW_OP_FORCED_RESET);
   endsequence

   property p_reboot_now;
      s_reboot_req |=> o_reboot && !o_cmd_enable;
   endproperty
   a_reboot_now: assert property (p_reboot_now)
      else $error("reboot action did not reboot");

   property p_no_cmds_in_reboot;
      o_reboot |-> !o_cmd_enable && !o_hw_kick;
   endproperty
   a_no_cmds_in_reboot: assert property (p_no_cmds_in_reboot)
      else $error("commands enabled during reboot");

   property p_io_reset;
      o_io_reset == !o_cmd_enable;
   endproperty
   a_io_reset: assert property (p_io_reset)
      else $error("io module reset out of step");

   property p_forced_stop;
      s_forced_req |=> (o_hw_reset_req && !o_hw_kick)[*8];
   endproperty
   a_forced_stop: assert property (p_forced_stop)
      else $error("watchdog still kicked after forced reset");

   property p_halt_sticky;
      o_hw_reset_req |=> o_hw_reset_req && !o_cmd_enable;
   endproperty
   a_halt_sticky: assert property (p_halt_sticky)
      else $error("gateway resumed before watchdog reset");

   property p_flag_clear;
      i_ce && act && is_op(i_act_opcode, `GRW_OP_FLAG_CLEAR) |=>
         o_status == (($past(o_status) & ~$past(i_act_param)) |
                      $past(i_status_set));
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("masked flag clear wrong");

   property p_interval_prog;
      i_ce && act && is_op(i_act_opcode, `GRW_OP_TIMEOUT_PROG) |=>
         o_interval == $past(i_act_param) && cnt_ff == 8'h00;
   endproperty
   a_interval_prog: assert property (p_interval_prog)
      else $error("interval program not immediate");

   property p_disabled;
      o_interval == 8'h00 |-> !expire;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled watchdog expired");

   property p_expire;
      i_ce && expire |=> o_hw_reset_req && !o_cmd_enable;
   endproperty
   a_expire: assert property (p_expire)
      else $error("expiry did not force reset");

   property p_default_interval;
      $past(i_rst) |-> o_interval == `GRW_INTERVAL_RST;
   endproperty
   a_default_interval: assert property (p_default_interval)
      else $error("interval not default after reset");

   property p_pkt_restart;
      i_ce && run && i_pkt_valid |=> cnt_ff == 8'h00;
   endproperty
   a_pkt_restart: assert property (p_pkt_restart)
      else $error("packet did not restart watchdog");

endmodule // grw_actions

/* File: hdl/grw_regs.svh */
// constants of the gateway reset and watchdog action block
// assumes a 50 MHz reference clock
`ifndef GRW_REGS_SVH
`define GRW_REGS_SVH

// action opcodes
`define GRW_OP_REBOOT 8'hf0
`define GRW_OP_FORCED_RESET 8'hf1
`define GRW_OP_FLAG_CLEAR 8'hf2
`define GRW_OP_TIMEOUT_PROG 8'hf3

// status byte layout and reset value
`define GRW_HARD_RESET_LINK_FLAG_BIT 7
`define GRW_RESET_SEEN_FLAG_BIT 6
`define GRW_STATUS_RST 8'h40

// communication watchdog interval after reset, in 100 ms steps
`define GRW_INTERVAL_RST 8'h64

// timing
`define GRW_CLK_KHZ 50000
`define GRW_TICK_MS 100
`define GRW_TICK_CYC (`GRW_TICK_MS * `GRW_CLK_KHZ)

`endif

/* File: hdl/grw_pkg.sv */
// types of the gateway reset and watchdog action block
// assumes grw_regs.svh for the numeric constants
package grw_pkg;

   typedef enum logic [2:0]
   {
      GRW_ST_RUN = 3'b001,
      GRW_ST_REBOOT = 3'b010,
      GRW_ST_HALT = 3'b100
   } grw_state_t;

endpackage

/* File: hdl/grw_tick_gen.sv */
// 100 ms tick prescaler for the communication watchdog
// assumes the caller restarts it together with the watchdog count
`timescale 1ns/1ps

module grw_tick_gen
#(
   parameter int unsigned TICK_CYC = 32'd5000000
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_clr,
   output logic o_tick
);

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   ////////////////////////////////////////////////////////////////////////
   // prescaler
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      if (i_clr)
      begin
         nxt_cnt = 32'h0;
      end
      else if (cnt_ff == TICK_CYC - 32'd1)
      begin
         nxt_cnt = 32'h0;
         nxt_tick = 1'b1;
      end
      else
      begin
         nxt_cnt = cnt_ff + 32'd1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign o_tick = tick_ff;

endmodule // grw_tick_gen

/* File: verification/grw_client.sv */
// remote client model: presents gateway actions and packet events
// assumes one action per command, driven after the clock edge
`timescale 1ns/1ps

module grw_client
(
   input wire logic i_ref_clk,
   output logic o_act_valid,
   output logic [7:0] o_act_opcode,
   output logic [7:0] o_act_param,
   output logic o_pkt_valid
);
   initial
   begin
      o_act_valid = 1'b0;
      o_act_opcode = 8'h00;
      o_act_param = 8'h00;
      o_pkt_valid = 1'b0;
   end

   ///////////////////////////////////////////////////////////////////////
   // gateway action, module id 0xff implied by the port
   // callers keep bit 7 out of clear masks
   // forced reset issued only by diagnostic scenarios
   // after a reset action the caller resets and polls status
   task automatic act(input logic [7:0] op, input logic [7:0] prm);
      @(posedge i_ref_clk);
      o_act_valid <= 1'b1;
      o_act_opcode <= op;
      o_act_param <= prm;
      o_pkt_valid <= 1'b1;
      @(posedge i_ref_clk);
      o_act_valid <= 1'b0;
      o_pkt_valid <= 1'b0;
      o_act_opcode <= ~op;
      o_act_param <= ~prm;
   endtask

   // plain valid packet with no gateway action
   task automatic pkt();
      @(posedge i_ref_clk);
      o_pkt_valid <= 1'b1;
      @(posedge i_ref_clk);
      o_pkt_valid <= 1'b0;
   endtask
endmodule // grw_client

/* File: verification/testbench.sv */
// self-checking bench of the gateway reset and watchdog actions
// assumes a 20 ns clock and a prescaler of 10 cycles per tick
`timescale 1ns/1ps

module testbench;
   localparam int unsigned TC = 10;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic [7:0] i_status_set = 8'h00;
   logic av, pv;
   logic [7:0] aop, apr;
   logic o_cmd_enable, o_reboot, o_io_reset, o_hw_kick, o_hw_reset_req;
   logic [7:0] o_status, o_interval;
   int failures = 0;
   int cmp_count = 0;
   int kicks;
   typedef struct {logic [7:0] op, prm, set, st, itv;} row_t;
   row_t rows[6] = '{
      '{8'hf2, 8'h03, 8'h0f, 8'h4c, 8'h64},
      '{8'hf2, 8'h40, 8'hf0, 8'hbc, 8'h64},
      '{8'hf3, 8'h05, 8'h00, 8'hbc, 8'h05},
      '{8'hf2, 8'h7f, 8'h00, 8'h80, 8'h05},
      '{8'hf5, 8'h01, 8'h01, 8'h81, 8'h05},
      '{8'hf3, 8'hff, 8'h00, 8'h81, 8'hff}};

   initial
   begin
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   grw_client client
   (
      .i_ref_clk(i_ref_clk),
      .o_act_valid(av),
      .o_act_opcode(aop),
      .o_act_param(apr),
      .o_pkt_valid(pv)
   );

   grw_actions #(.TICK_CYC(TC)) DUT
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_act_valid(av),
      .i_act_opcode(aop),
      .i_act_param(apr),
      .i_pkt_valid(pv),
      .i_status_set(i_status_set),
      .o_cmd_enable(o_cmd_enable),
      .o_reboot(o_reboot),
      .o_io_reset(o_io_reset),
      .o_hw_kick(o_hw_kick),
      .o_hw_reset_req(o_hw_reset_req),
      .o_status(o_status),
      .o_interval(o_interval)
   );

   ///////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic rst_dut();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      wt(1);
      chk("status", o_status, 8'h40);
      chk("interval", o_interval, 8'h64);
      chk("io_reset", {7'h0, o_io_reset}, 8'h00);
      @(posedge i_ref_clk);
      i_rst <= 1'b0;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #60000;
      failures++;
      summarize();
   end

   ///////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_dut();
      foreach (rows[i])
      begin
         @(posedge i_ref_clk);
         i_status_set <= rows[i].set;
         @(posedge i_ref_clk);
         i_status_set <= 8'h00;
         client.act(rows[i].op, rows[i].prm);
         #1;
         chk("status", o_status, rows[i].st);
         chk("interval", o_interval, rows[i].itv);
      end
      // clock enable low freezes the block, the action is lost
      @(posedge i_ref_clk);
      i_ce <= 1'b0;
      client.act(8'hf3, 8'h09);
      #1;
      chk("ce_interval", o_interval, 8'hff);
      @(posedge i_ref_clk);
      i_ce <= 1'b1;
      // flag set and clear in one cycle: the set wins
      fork
         client.act(8'hf2, 8'h03);
         begin
            @(posedge i_ref_clk);
            i_status_set <= 8'h02;
            @(posedge i_ref_clk);
            i_status_set <= 8'h00;
         end
      join
      #1;
      chk("set_wins", o_status, 8'h82);
      // short interval: packet restarts the count, silence expires it
      client.act(8'hf3, 8'h03);
      wt(2 * TC);
      client.pkt();
      wt(2 * TC);
      chk("early_req", {7'h0, o_hw_reset_req}, 8'h00);
      wt(2 * TC);
      chk("timeout_req", {7'h0, o_hw_reset_req}, 8'h01);
      chk("timeout_en", {7'h0, o_cmd_enable}, 8'h00);
      rst_dut();
      // interval zero disables, kicks keep coming
      client.act(8'hf3, 8'h00);
      kicks = 0;
      repeat (10 * TC)
      begin
         wt(1);
         kicks += o_hw_kick;
      end
      chk("disabled", {7'h0, o_hw_reset_req}, 8'h00);
      chk("kicks", 8'(kicks >= 9 && kicks <= 11), 8'h01);
      // reboot, then refused clear
      client.act(8'hf0, 8'h00);
      #1;
      chk("reboot", {7'h0, o_reboot}, 8'h01);
      chk("cmd_en", {7'h0, o_cmd_enable}, 8'h00);
      chk("io_reset", {7'h0, o_io_reset}, 8'h01);
      client.act(8'hf2, 8'h40);
      #1;
      chk("refused", o_status, 8'h40);
      rst_dut();
      // forced reset: no more kicks, gateway idle
      client.act(8'hf1, 8'h00);
      #1;
      chk("hw_req", {7'h0, o_hw_reset_req}, 8'h01);
      chk("io_reset", {7'h0, o_io_reset}, 8'h01);
      kicks = 0;
      repeat (5 * TC)
      begin
         wt(1);
         kicks += o_hw_kick;
      end
      chk("kicks", 8'(kicks), 8'h00);
      client.act(8'hf3, 8'h07);
      #1;
      chk("halted", o_interval, 8'h64);
      rst_dut();
      summarize();
   end
endmodule // testbench
